// file: core/gsc_params.svh
/*
  Offsets, field positions, reset values and decode limits of the
  gain step control registers.
  Assumes an 8-bit register address and 8-bit register data.
*/
`ifndef GSC_PARAMS_SVH
`define GSC_PARAMS_SVH

`define GSC_ADDR_W          8
`define GSC_DATA_W          8
`define GSC_ADDR_RX_COARSE  8'h27
`define GSC_ADDR_TX_FINE    8'h28
`define GSC_REG_RESET       5'h00
`define GSC_RDATA_RESET     8'h00
`define GSC_UNMAPPED_READ   8'h00
`define GSC_RSVD_ZERO       3'h0
`define GSC_SIGN_BIT        4
`define GSC_MAG_MSB         3
`define GSC_MAG_LSB         0
`define GSC_MAG_ZERO        4'h0
`define GSC_MAG_FULL        4'hF
`define GSC_SAT_TOP         2'h3
`define GSC_RX_GAIN_LIMIT   6'h0C
`define GSC_RX_STEP_UNITS   6'h01
`define GSC_TX_STEP_UNITS   6'h01
`define GSC_GAIN_ZERO       6'h00

`endif

// file: core/gsc_pkg.sv
/*
  Types shared by the gain step control top, its decoders and the
  setting interface.
  Assumes gsc_params.svh is on the include path.
*/
package gsc_pkg;

  // Sign in bit 4, magnitude in bits 3 to 0, as stored in a register.
  typedef struct packed {
    logic       sign;
    logic [3:0] mag;
  } gsc_field_type;

  // Signed gain in register steps; negative means attenuation.
  typedef logic signed [5:0] gsc_gain_type;

  typedef struct packed {
    gsc_field_type rx_reg;
    gsc_field_type tx_reg;
    logic [7:0]    rd_data;
    gsc_gain_type  rx_gain;
    gsc_gain_type  tx_gain;
    logic          rx_upd;
    logic          tx_upd;
  } gsc_state_type;

endpackage

// file: core/gsc_setting_if.sv
/*
  Carrier between a stored gain field and its decoder.
  Assumes the gsc_pkg package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

interface gsc_setting_if;
  import gsc_pkg::*;

  gsc_field_type field;
  gsc_gain_type  gain;

  modport owner   (output field, input gain);
  modport decoder (input field, output gain);
endinterface

`default_nettype wire

// file: core/gsc_rx_coarse_decode.sv
/*
  Decodes the receive coarse field into a signed count of 1 dB steps.
  Assumes a stored field at its input; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gsc_params.svh"

module gsc_rx_coarse_decode
  import gsc_pkg::*;
(
  gsc_setting_if.decoder set
);

  gsc_gain_type mag_steps;

  always_comb begin
    mag_steps = 6'({2'h0, set.field.mag} * `GSC_RX_STEP_UNITS);
    if (set.field.mag == `GSC_MAG_ZERO) begin
      set.gain = `GSC_GAIN_ZERO;
    end else if (set.field.sign) begin
      set.gain = -mag_steps;
    end else if (set.field.mag[3:2] == `GSC_SAT_TOP) begin
      set.gain = `GSC_RX_GAIN_LIMIT;
    end else begin
      set.gain = mag_steps;
    end
  end

endmodule

`default_nettype wire

// file: core/gsc_tx_fine_decode.sv
/*
  Decodes the transmit fine field into a signed count of 0.1 dB steps.
  Assumes a stored field at its input; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gsc_params.svh"

module gsc_tx_fine_decode
  import gsc_pkg::*;
(
  gsc_setting_if.decoder set
);

  gsc_gain_type mag_steps;

  always_comb begin
    mag_steps = 6'({2'h0, set.field.mag} * `GSC_TX_STEP_UNITS);
    if (set.field.mag == `GSC_MAG_ZERO) begin
      set.gain = `GSC_GAIN_ZERO;
    end else if (set.field.sign) begin
      set.gain = -mag_steps;
    end else begin
      set.gain = mag_steps;
    end
  end

endmodule

`default_nettype wire

// file: core/gsc_top.sv
/*
  Gain step control register bank: receive coarse gain and transmit
  fine gain, each decoded into a signed setting for the datapath.
  Assumes a register master on the same clock that uses one-cycle
  strobes and never asserts read and write together.
*/
// Behaviour
// - Both gain registers clear to zero on reset, giving 0 dB.
// - Receive coarse bit 4 clear raises gain, set adds attenuation.
// - Receive coarse magnitude in bits 3 to 0 counts 1 dB per step.
// - Receive gain with magnitude 11xx saturates at 12 dB.
// - Receive attenuation with magnitude 1111 reaches 15 dB.
// - Receive coarse magnitude zero gives 0 dB whatever the sign.
// - Transmit fine bit 4 clear raises gain, set adds attenuation.
// - Transmit fine magnitude counts 0.1 dB per step, up to 1.5 dB.
// - Transmit fine magnitude zero gives 0 dB whatever the sign.
`timescale 1ns/1ps
`default_nettype none
`include "gsc_params.svh"

module gsc_top
  import gsc_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [`GSC_ADDR_W-1:0]  addr,
  input  wire logic [`GSC_DATA_W-1:0]  wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic      [`GSC_DATA_W-1:0]  rd_data,
  output logic signed [5:0]            rx_gain_db,
  output logic signed [5:0]            tx_gain_tenth_db,
  output logic                         rx_gain_update,
  output logic                         tx_gain_update
);

  gsc_state_type state_ff;
  gsc_state_type nxt_state;

  gsc_setting_if rx_set ();
  gsc_setting_if tx_set ();

  logic          hit_rx;
  logic          hit_tx;
  gsc_field_type wr_field;

  // The decoders see only the stored fields, so a write changes the
  // datapath no earlier than the edge after the register took it.
  assign rx_set.field = state_ff.rx_reg;
  assign tx_set.field = state_ff.tx_reg;

  gsc_rx_coarse_decode u_rx_decode (
    .set (rx_set)
  );

  gsc_tx_fine_decode u_tx_decode (
    .set (tx_set)
  );

  always_comb begin
    hit_rx = 1'b0;
    hit_tx = 1'b0;
    if (addr == `GSC_ADDR_RX_COARSE) begin
      hit_rx = 1'b1;
    end else if (addr == `GSC_ADDR_TX_FINE) begin
      hit_tx = 1'b1;
    end
  end

  // Bits 7 to 5 are dropped here and never stored.
  assign wr_field = gsc_field_type'(wr_data[`GSC_SIGN_BIT:0]);

  always_comb begin
    nxt_state = state_ff;
    if (wr_en && hit_rx) begin
      nxt_state.rx_reg = wr_field;
    end
    if (wr_en && hit_tx) begin
      nxt_state.tx_reg = wr_field;
    end
    // Read data stand for one cycle only; zero otherwise.
    nxt_state.rd_data = `GSC_RDATA_RESET;
    if (rd_en) begin
      if (hit_rx) begin
        nxt_state.rd_data = {`GSC_RSVD_ZERO, state_ff.rx_reg};
      end else if (hit_tx) begin
        nxt_state.rd_data = {`GSC_RSVD_ZERO, state_ff.tx_reg};
      end else begin
        nxt_state.rd_data = `GSC_UNMAPPED_READ;
      end
    end
    nxt_state.rx_gain = rx_set.gain;
    nxt_state.tx_gain = tx_set.gain;
    nxt_state.rx_upd  = (rx_set.gain != state_ff.rx_gain);
    nxt_state.tx_upd  = (tx_set.gain != state_ff.tx_gain);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data          = state_ff.rd_data;
  assign rx_gain_db       = state_ff.rx_gain;
  assign tx_gain_tenth_db = state_ff.tx_gain;
  assign rx_gain_update   = state_ff.rx_upd;
  assign tx_gain_update   = state_ff.tx_upd;

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  logic wr_rx;
  logic wr_tx;

  assign wr_rx = wr_en && hit_rx;
  assign wr_tx = wr_en && hit_tx;

  property p_reset_clears;
    @(posedge clk) disable iff (1'b0)
      rst |=> (state_ff.rx_reg == `GSC_REG_RESET)
           && (state_ff.tx_reg == `GSC_REG_RESET)
           && (rx_gain_db == `GSC_GAIN_ZERO)
           && (tx_gain_tenth_db == `GSC_GAIN_ZERO);
  endproperty

  a_reset_clears_regs: assert property (p_reset_clears)
    else $error("Gain registers not zero after reset.");

  a_reserved_reads_zero: assert property (
    rd_en |=> rd_data[7:5] == `GSC_RSVD_ZERO)
    else $error("Reserved bits read back nonzero.");

  a_rx_readback_value: assert property (
    (rd_en && hit_rx && !wr_en)
      |=> rd_data == {`GSC_RSVD_ZERO, $past(state_ff.rx_reg)})
    else $error("Receive coarse readback does not match store.");

  a_tx_write_readback: assert property (
    (wr_tx ##1 (rd_en && hit_tx))
      |=> rd_data == {`GSC_RSVD_ZERO, $past(wr_data[4:0], 2)})
    else $error("Transmit fine readback lost the written field.");

  a_rx_gain_dir: assert property (
    (wr_rx && !wr_data[4] && wr_data[3:2] != `GSC_SAT_TOP)
      |-> ##2 rx_gain_db == $signed({2'h0, $past(wr_data[3:0], 2)}))
    else $error("Receive gain does not follow the magnitude.");

  a_rx_atten_step: assert property (
    (wr_rx && wr_data[4])
      |-> ##2 rx_gain_db == -$signed({2'h0, $past(wr_data[3:0], 2)}))
    else $error("Receive attenuation is not one dB per count.");

  a_rx_gain_saturate: assert property (
    (wr_rx && !wr_data[4] && wr_data[3:2] == `GSC_SAT_TOP)
      |-> ##2 rx_gain_db == $signed(`GSC_RX_GAIN_LIMIT))
    else $error("Receive gain did not saturate at twelve dB.");

  a_rx_atten_full: assert property (
    (wr_rx && wr_data[4] && wr_data[3:0] == `GSC_MAG_FULL)
      |-> ##2 rx_gain_db == -6'sd15)
    else $error("Receive full attenuation is not fifteen dB.");

  a_rx_zero_mag: assert property (
    (wr_rx && wr_data[3:0] == `GSC_MAG_ZERO)
      |-> ##2 rx_gain_db == `GSC_GAIN_ZERO)
    else $error("Receive zero magnitude does not give 0 dB.");

  a_tx_gain_dir: assert property (
    (wr_tx && wr_data[3:0] != `GSC_MAG_ZERO)
      |-> ##2 ((tx_gain_tenth_db < 0) == $past(wr_data[4], 2)))
    else $error("Transmit sign bit chose the wrong direction.");

  a_tx_fine_step: assert property (
    wr_tx |-> ##2 (tx_gain_tenth_db == ($past(wr_data[4], 2)
      ? -$signed({2'h0, $past(wr_data[3:0], 2)})
      :  $signed({2'h0, $past(wr_data[3:0], 2)})))
    ) else $error("Transmit fine step is not one tenth dB per count.");

  a_tx_zero_mag: assert property (
    (wr_tx && wr_data[3:0] == `GSC_MAG_ZERO)
      |-> ##2 tx_gain_tenth_db == `GSC_GAIN_ZERO)
    else $error("Transmit zero magnitude does not give 0 dB.");

  // A reset moves the settings without any write, so the checks on a
  // change excuse the cycle that follows a reset.
  a_rx_change_cause: assert property (
    $changed(rx_gain_db) |-> $past(wr_rx, 2) || $past(rst))
    else $error("Receive setting changed without a write.");

  a_tx_change_cause: assert property (
    $changed(tx_gain_tenth_db) |-> $past(wr_tx, 2) || $past(rst))
    else $error("Transmit setting changed without a write.");

  a_rx_update_pulse: assert property (
    rx_gain_update == ($changed(rx_gain_db) && !$past(rst)))
    else $error("Receive update pulse out of step with setting.");

  a_tx_update_pulse: assert property (
    tx_gain_update == ($changed(tx_gain_tenth_db) && !$past(rst)))
    else $error("Transmit update pulse out of step with setting.");

  a_rx_update_cause: assert property (
    rx_gain_update |-> $past(wr_rx, 2))
    else $error("Receive update pulse without a receive write.");

  a_tx_update_cause: assert property (
    tx_gain_update |-> $past(wr_tx, 2))
    else $error("Transmit update pulse without a transmit write.");

  a_rd_idle_zero: assert property (
    !rd_en |=> rd_data == `GSC_RDATA_RESET)
    else $error("Read data did not return to zero after the read.");

  a_unmapped_read_zero: assert property (
    (rd_en && !hit_rx && !hit_tx) |=> rd_data == `GSC_UNMAPPED_READ)
    else $error("Unmapped read returned nonzero data.");

  a_tx_readback_value: assert property (
    (rd_en && hit_tx && !wr_en)
      |=> rd_data == {`GSC_RSVD_ZERO, $past(state_ff.tx_reg)})
    else $error("Transmit fine readback does not match store.");

  a_rx_write_readback: assert property (
    (wr_rx ##1 (rd_en && hit_rx))
      |=> rd_data == {`GSC_RSVD_ZERO, $past(wr_data[4:0], 2)})
    else $error("Receive coarse readback lost the written field.");

  a_rd_upper_zero: assert property (
    rd_data[7:5] == `GSC_RSVD_ZERO)
    else $error("Reserved read bits are not zero.");

  a_rx_reg_write: assert property (
    wr_rx |=> state_ff.rx_reg == $past(wr_data[`GSC_SIGN_BIT:0]))
    else $error("Receive coarse write did not land.");

  a_tx_reg_write: assert property (
    wr_tx |=> state_ff.tx_reg == $past(wr_data[`GSC_SIGN_BIT:0]))
    else $error("Transmit fine write did not land.");

  a_rx_reg_holds: assert property (
    !wr_rx |=> $stable(state_ff.rx_reg))
    else $error("Receive coarse store moved without a write.");

  a_tx_reg_holds: assert property (
    !wr_tx |=> $stable(state_ff.tx_reg))
    else $error("Transmit fine store moved without a write.");

  a_rx_gain_holds: assert property (
    !wr_rx |-> ##2 $stable(rx_gain_db))
    else $error("Receive setting moved without a write.");

  a_tx_gain_holds: assert property (
    !wr_tx |-> ##2 $stable(tx_gain_tenth_db))
    else $error("Transmit setting moved without a write.");

  a_unmapped_write_keeps: assert property (
    (wr_en && !hit_rx && !hit_tx)
      |-> ##2 $stable(rx_gain_db) && $stable(tx_gain_tenth_db))
    else $error("Unmapped write moved a setting.");

  a_rx_gain_range: assert property (
    rx_gain_db >= -6'sh0F && rx_gain_db <= 6'sh0C)
    else $error("Receive setting outside its range.");

  a_tx_gain_range: assert property (
    tx_gain_tenth_db >= -6'sh0F && tx_gain_tenth_db <= 6'sh0F)
    else $error("Transmit setting outside its range.");

  a_rx_sign_atten: assert property (
    (wr_rx && wr_data[4])
      |-> ##2 rx_gain_db <= 6'sh00)
    else $error("Receive sign set did not attenuate.");

  a_tx_sign_atten: assert property (
    (wr_tx && wr_data[4])
      |-> ##2 tx_gain_tenth_db <= 6'sh00)
    else $error("Transmit sign set did not attenuate.");

  a_rx_sign_gain: assert property (
    (wr_rx && !wr_data[4] && wr_data[3:0] != `GSC_MAG_ZERO)
      |-> ##2 rx_gain_db > 6'sh00)
    else $error("Receive sign clear did not give gain.");

  a_tx_sign_gain: assert property (
    (wr_tx && !wr_data[4] && wr_data[3:0] != `GSC_MAG_ZERO)
      |-> ##2 tx_gain_tenth_db > 6'sh00)
    else $error("Transmit sign clear did not give gain.");

  a_rx_below_limit: assert property (
    (wr_rx && !wr_data[4] && wr_data[3:0] == 4'hB)
      |-> ##2 rx_gain_db == 6'sh0B)
    else $error("Receive gain saturated below its limit.");

  a_rx_zero_signed: assert property (
    (wr_rx && wr_data[4] && wr_data[3:0] == `GSC_MAG_ZERO)
      |-> ##2 rx_gain_db == 6'sh00)
    else $error("Receive signed zero magnitude is not 0 dB.");

  a_tx_zero_signed: assert property (
    (wr_tx && wr_data[4] && wr_data[3:0] == `GSC_MAG_ZERO)
      |-> ##2 tx_gain_tenth_db == 6'sh00)
    else $error("Transmit signed zero magnitude is not 0 dB.");

  a_tx_full_atten: assert property (
    (wr_tx && wr_data[4] && wr_data[3:0] == `GSC_MAG_FULL)
      |-> ##2 tx_gain_tenth_db == -6'sh0F)
    else $error("Transmit full attenuation is not fifteen steps.");

  a_tx_full_gain: assert property (
    (wr_tx && !wr_data[4] && wr_data[3:0] == `GSC_MAG_FULL)
      |-> ##2 tx_gain_tenth_db == 6'sh0F)
    else $error("Transmit full gain is not fifteen steps.");

  a_reset_quiet_outputs: assert property (
    @(posedge clk) disable iff (1'b0)
      rst |=> rd_data == `GSC_RDATA_RESET && !rx_gain_update
        && !tx_gain_update)
    else $error("Read data or update pulses not quiet after reset.");

  c_rx_saturate: cover property (
    wr_rx && !wr_data[4] && wr_data[3:0] == `GSC_MAG_FULL ##2
      rx_gain_db == $signed(`GSC_RX_GAIN_LIMIT));

  c_rx_full_atten: cover property (
    wr_rx && wr_data[4] && wr_data[3:0] == `GSC_MAG_FULL);

  c_tx_write_then_read: cover property (
    wr_tx ##1 (rd_en && hit_tx));

  c_unmapped_read: cover property (
    rd_en && !hit_rx && !hit_tx);

  c_rx_write_then_read: cover property (
    wr_rx ##1 (rd_en && hit_rx));

endmodule

`default_nettype wire

// file: sim/gsc_top_bench.sv
/*
  Self-checking bench for the gain step control register bank.
  Assumes gsc_pkg is compiled first and gsc_params.svh is on the
  include path; the bench drives every input port of gsc_top itself.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gsc_params.svh"

module gsc_top_bench
  import gsc_pkg::*;
;
  logic              clk      = 1'b0;
  logic              rst      = 1'b1;
  logic [7:0]        addr     = 8'h00;
  logic [7:0]        wr_data  = 8'h00;
  logic              wr_en    = 1'b0;
  logic              rd_en    = 1'b0;
  logic [7:0]        rd_data;
  logic signed [5:0] rx_gain_db;
  logic signed [5:0] tx_gain_tenth_db;
  logic              rx_gain_update;
  logic              tx_gain_update;
  logic [4:0]        rx_q     = 5'h00;
  logic [4:0]        tx_q     = 5'h00;
  int                errors   = 0;
  int                total_checks = 0;

  gsc_top dut (
    .clk              (clk),
    .rst              (rst),
    .addr             (addr),
    .wr_data          (wr_data),
    .wr_en            (wr_en),
    .rd_en            (rd_en),
    .rd_data          (rd_data),
    .rx_gain_db       (rx_gain_db),
    .tx_gain_tenth_db (tx_gain_tenth_db),
    .rx_gain_update   (rx_gain_update),
    .tx_gain_update   (tx_gain_update)
  );

  always #4 clk = ~clk;

  function automatic gsc_gain_type rx_exp(input logic [4:0] f);
    if (f[3:0] == 4'h0) return 6'h00;
    if (!f[4] && f[3:2] == 2'h3) return 6'h0C;
    if (!f[4]) return {2'h0, f[3:0]};
    return -$signed({2'h0, f[3:0]});
  endfunction

  function automatic gsc_gain_type tx_exp(input logic [4:0] f);
    if (f[4]) return -$signed({2'h0, f[3:0]});
    return {2'h0, f[3:0]};
  endfunction

  task automatic chk8(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk6(input string n, input gsc_gain_type e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkp(input string n, input logic [3:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic close_out;
    if (errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask

  // Reads check the answer cycle and the idle cycle after it.
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = (a == `GSC_ADDR_RX_COARSE) ? {3'h0, rx_q} :
        (a == `GSC_ADDR_TX_FINE) ? {3'h0, tx_q} : 8'h00;
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk8("rd_data", e, rd_data);
    @(negedge clk);
    chk8("rd_data idle", 8'h00, rd_data);
  endtask

  // A read with no gap after a write must already see the new field.
  task automatic wr_then_rd(input logic [7:0] a, d);
    wr(a, d);
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    if (a == `GSC_ADDR_RX_COARSE) rx_q = d[4:0];
    if (a == `GSC_ADDR_TX_FINE) tx_q = d[4:0];
    @(negedge clk);
    chk8("rd_data after write", {3'h0, d[4:0]}, rd_data);
  endtask

  // A pulse is owed only when the decoded setting really moves.
  task automatic apply(input logic [7:0] a, d);
    gsc_gain_type ro;
    gsc_gain_type to;
    logic [3:0]   nr;
    logic [3:0]   nt;
    ro = rx_exp(rx_q);
    to = tx_exp(tx_q);
    nr = 4'h0;
    nt = 4'h0;
    wr(a, d);
    if (a == `GSC_ADDR_RX_COARSE) rx_q = d[4:0];
    if (a == `GSC_ADDR_TX_FINE) tx_q = d[4:0];
    repeat (6) begin
      @(negedge clk);
      nr += {3'h0, rx_gain_update};
      nt += {3'h0, tx_gain_update};
    end
    chkp("rx pulses", {3'h0, ro !== rx_exp(rx_q)}, nr);
    chkp("tx pulses", {3'h0, to !== tx_exp(tx_q)}, nt);
    chk6("rx_gain_db", rx_exp(rx_q), rx_gain_db);
    chk6("tx_gain", tx_exp(tx_q), tx_gain_tenth_db);
    rd(a);
  endtask

  task automatic reset_check;
    @(negedge clk);
    chk6("rx_gain_db", 6'h00, rx_gain_db);
    chk6("tx_gain", 6'h00, tx_gain_tenth_db);
    chkp("update", 4'h0, {2'h0, rx_gain_update, tx_gain_update});
    rd(`GSC_ADDR_RX_COARSE);
    rd(`GSC_ADDR_TX_FINE);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  initial begin
    logic [7:0] a;
    void'($urandom(25848));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    reset_check();
    // Every sign and magnitude, with junk in the reserved bits.
    for (int i = 0; i < 32; i++) begin
      apply(`GSC_ADDR_RX_COARSE, {3'($urandom), 5'(i)});
      apply(`GSC_ADDR_TX_FINE, {3'($urandom), 5'(i)});
    end
    rd(8'h00);
    rd(8'hFF);
    for (int i = 0; i < 60; i++) begin
      case ($urandom % 3)
        0: a = `GSC_ADDR_RX_COARSE;
        1: a = `GSC_ADDR_TX_FINE;
        default: a = 8'($urandom);
      endcase
      apply(a, 8'($urandom));
    end
    // Back to back strobes, leaving nonzero fields for the reset.
    wr_then_rd(`GSC_ADDR_RX_COARSE, 8'hFF);
    wr_then_rd(`GSC_ADDR_TX_FINE, 8'hEC);
    wr_then_rd(`GSC_ADDR_TX_FINE, 8'h95);
    // A second reset in mid-run must clear both settings again.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rx_q = 5'h00;
    tx_q = 5'h00;
    reset_check();
    close_out();
  end
endmodule

`default_nettype wire
